// ==== rtl/dcr_pkg.sv ====
// Constants and carrier types for the deserializer configuration register bank
package dcr_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CONFIG_ONE   = 8'h00;
  localparam logic [7:0] OFS_SLAVE_ADDR   = 8'h01;
  localparam logic [7:0] OFS_FEATURES_ONE = 8'h02;

  // Reset values
  localparam logic [7:0] RST_CONFIG_ONE   = 8'h00;
  localparam logic [7:0] RST_SLAVE_ADDR   = 8'h70;
  localparam logic [7:0] RST_FEATURES_ONE = 8'h00;

  // Config one fields
  localparam int LF_RANGE_BIT    = 7;
  localparam int CLK_SLEW_BIT    = 6;
  localparam int DATA_SLEW_BIT   = 5;
  localparam int STROBE_EDGE_BIT = 4;
  localparam int MODE_MSB        = 3;
  localparam int MODE_LSB        = 2;
  localparam int SLEEP_BIT       = 1;
  localparam int REG_CONTROL_BIT = 0;

  // Slave address fields
  localparam int ADDR_SRC_BIT = 7;
  localparam int ADDR_MSB     = 6;

  // Features one fields
  localparam int HOLD_LOW_BIT     = 7;
  localparam int SLEEP_STATE_BIT  = 6;
  localparam int STRAP_BYPASS_BIT = 3;
  localparam int OSC_MSB          = 2;

  // Mode and oscillator codes
  localparam logic [1:0] MODE_FILTER_OFF = 2'h0;
  localparam logic [1:0] MODE_FILTER_ON  = 2'h1;
  localparam logic [2:0] OSC_OFF         = 3'h0;
  localparam logic [2:0] OSC_UNDEFINED   = 3'h5;

  // The four legal slave addresses, picked by the address select pin
  localparam logic [6:0] SLAVE_ADDR_0 = 7'h71;
  localparam logic [6:0] SLAVE_ADDR_1 = 7'h72;
  localparam logic [6:0] SLAVE_ADDR_2 = 7'h73;
  localparam logic [6:0] SLAVE_ADDR_3 = 7'h76;

  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef struct packed {
    logic       low_freq_spread_range;
    logic       clock_output_slew_boost;
    logic       data_output_slew_boost;
    logic       output_strobe_edge_select;
    logic       filter_enable;
    logic [2:0] oscillator_freq_select;
  } dcr_cfg_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } dcr_state_e;

endpackage : dcr_pkg

// ==== rtl/dcr_config_regs.sv ====
// Deserializer configuration register bank behind a two-wire serial control port
// Summary of operation
// - Config bit 7 picks spread range
// - Config bit 6 boosts clock output slew
// - Config bit 5 boosts data output slew
// - Config bit 4 picks output strobe edge
// - Config bits 3:2 enable control filter
// - Config bit 1 enters sleep, registers kept
// - Config bit 0 picks pins or registers
// - Address bit 7 picks pin or register
// - Address bits 6:0 hold legal address
// - Features bit 7 clear holds outputs low while locked, strap set
// - Features bit 6 sets sleep output state
// - Features bit 3 overrides hold-low strap
// - Features bits 2:0 pick oscillator frequency
`timescale 1ns/1ns
`default_nettype none

module dcr_config_regs (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // Serial control port
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  // Pins and straps
  input  wire logic [1:0]              address_select_pin,
  input  wire dcr_pkg::dcr_cfg_s       pin_cfg,
  input  wire logic                    hold_low_strap,
  input  wire logic                    lock_status,
  // Effective settings
  output dcr_pkg::dcr_cfg_s            eff_cfg,
  output logic                         sleep_mode,
  output logic                         out_drive_enable,
  output logic                         out_force_low,
  output logic                         pass_force_high
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]              config_one_reg, slave_addr_reg, features_one_reg, rdata;
  logic [7:0]              shift_reg, tx_reg, ptr_reg, wr_addr_reg, wr_data_reg;
  logic [6:0]              pin_addr, active_addr;
  logic [3:0]              bit_cnt_reg;
  logic                    scl_prev_reg, sda_prev_reg, rw_reg, master_ack_reg, wr_stb_reg;
  logic                    sda_oe_reg, sleep_reg, drive_en_reg, force_low_reg, pass_high_reg;
  logic                    scl_rise, scl_fall, start_cond, stop_cond, hold_low_feature;
  dcr_pkg::dcr_state_e     state_reg;
  dcr_pkg::dcr_cfg_s       eff_cfg_reg, reg_cfg;
  assign scl_rise   = scl_in & ~scl_prev_reg;
  assign scl_fall   = ~scl_in & scl_prev_reg;
  assign start_cond = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
  assign stop_cond  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
  always_comb
  begin
    unique case (address_select_pin)
      2'h0:    pin_addr = dcr_pkg::SLAVE_ADDR_0;
      2'h1:    pin_addr = dcr_pkg::SLAVE_ADDR_1;
      2'h2:    pin_addr = dcr_pkg::SLAVE_ADDR_2;
      default: pin_addr = dcr_pkg::SLAVE_ADDR_3;
    endcase
  end

  // Register address is taken as written; legality is the host's duty
  assign active_addr = slave_addr_reg[dcr_pkg::ADDR_SRC_BIT] ?
                       slave_addr_reg[dcr_pkg::ADDR_MSB:0] : pin_addr;
  always_comb
  begin
    unique case (ptr_reg)
      dcr_pkg::OFS_CONFIG_ONE:   rdata = config_one_reg;
      dcr_pkg::OFS_SLAVE_ADDR:   rdata = slave_addr_reg;
      dcr_pkg::OFS_FEATURES_ONE: rdata = features_one_reg;
      default:                   rdata = 8'h00;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // Line sampling
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Serial protocol engine; data moves on clock low, sampled on rise
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg      <= dcr_pkg::ST_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      tx_reg         <= 8'h00;
      ptr_reg        <= 8'h00;
      rw_reg         <= 1'b0;
      master_ack_reg <= 1'b0;
      wr_stb_reg     <= 1'b0;
      wr_addr_reg    <= 8'h00;
      wr_data_reg    <= 8'h00;
      sda_oe_reg     <= 1'b0;
    end
    else
    begin
      wr_stb_reg <= 1'b0;
      if (start_cond)
      begin
        state_reg   <= dcr_pkg::ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg  <= 1'b0;
      end
      else if (stop_cond)
      begin
        state_reg  <= dcr_pkg::ST_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (state_reg == dcr_pkg::ST_RDATA_ACK)
          master_ack_reg <= ~sda_in;
        else if (bit_cnt_reg != dcr_pkg::BYTE_BITS)
        begin
          shift_reg   <= {shift_reg[6:0], sda_in};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end
      else if (scl_fall)
      begin
        unique case (state_reg)
          dcr_pkg::ST_IDLE: ;
          dcr_pkg::ST_ADDR:
            if (bit_cnt_reg == dcr_pkg::BYTE_BITS)
            begin
              if (shift_reg[7:1] == active_addr)
              begin
                rw_reg     <= shift_reg[0];
                sda_oe_reg <= 1'b1;
                state_reg  <= dcr_pkg::ST_ADDR_ACK;
              end
              else
                state_reg <= dcr_pkg::ST_IDLE;
            end
          dcr_pkg::ST_ADDR_ACK:
          begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg)
            begin
              tx_reg     <= rdata;
              ptr_reg    <= ptr_reg + 8'h01;
              sda_oe_reg <= ~rdata[7];
              state_reg  <= dcr_pkg::ST_RDATA;
            end
            else
            begin
              sda_oe_reg <= 1'b0;
              state_reg  <= dcr_pkg::ST_PTR;
            end
          end
          dcr_pkg::ST_PTR:
            if (bit_cnt_reg == dcr_pkg::BYTE_BITS)
            begin
              ptr_reg    <= shift_reg;
              sda_oe_reg <= 1'b1;
              state_reg  <= dcr_pkg::ST_PTR_ACK;
            end
          dcr_pkg::ST_PTR_ACK, dcr_pkg::ST_WDATA_ACK:
          begin
            sda_oe_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= dcr_pkg::ST_WDATA;
          end
          dcr_pkg::ST_WDATA:
            if (bit_cnt_reg == dcr_pkg::BYTE_BITS)
            begin
              wr_stb_reg  <= 1'b1;
              wr_addr_reg <= ptr_reg;
              wr_data_reg <= shift_reg;
              ptr_reg     <= ptr_reg + 8'h01;
              sda_oe_reg  <= 1'b1;
              state_reg   <= dcr_pkg::ST_WDATA_ACK;
            end
          dcr_pkg::ST_RDATA:
            if (bit_cnt_reg == dcr_pkg::BYTE_BITS)
            begin
              sda_oe_reg <= 1'b0;
              state_reg  <= dcr_pkg::ST_RDATA_ACK;
            end
            else
            begin
              tx_reg     <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
            end
          dcr_pkg::ST_RDATA_ACK:
          begin
            bit_cnt_reg <= 4'h0;
            if (master_ack_reg)
            begin
              tx_reg     <= rdata;
              ptr_reg    <= ptr_reg + 8'h01;
              sda_oe_reg <= ~rdata[7];
              state_reg  <= dcr_pkg::ST_RDATA;
            end
            else
              state_reg <= dcr_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register file; unmapped writes are dropped
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      config_one_reg   <= dcr_pkg::RST_CONFIG_ONE;
      slave_addr_reg   <= dcr_pkg::RST_SLAVE_ADDR;
      features_one_reg <= dcr_pkg::RST_FEATURES_ONE;
    end
    else if (wr_stb_reg)
    begin
      if (wr_addr_reg == dcr_pkg::OFS_CONFIG_ONE)
        config_one_reg <= wr_data_reg;
      if (wr_addr_reg == dcr_pkg::OFS_SLAVE_ADDR)
        slave_addr_reg <= wr_data_reg;
      // Bits 5:4 stored as written, they steer nothing
      if (wr_addr_reg == dcr_pkg::OFS_FEATURES_ONE)
        features_one_reg <= wr_data_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Effective settings
  always_comb
  begin
    reg_cfg.low_freq_spread_range     = config_one_reg[dcr_pkg::LF_RANGE_BIT];
    reg_cfg.clock_output_slew_boost   = config_one_reg[dcr_pkg::CLK_SLEW_BIT];
    reg_cfg.data_output_slew_boost    = config_one_reg[dcr_pkg::DATA_SLEW_BIT];
    reg_cfg.output_strobe_edge_select = config_one_reg[dcr_pkg::STROBE_EDGE_BIT];
    // Reserved mode codes leave the filter off
    reg_cfg.filter_enable =
      config_one_reg[dcr_pkg::MODE_MSB:dcr_pkg::MODE_LSB] == dcr_pkg::MODE_FILTER_ON;
    // Undefined code stops the oscillator rather than guessing a rate
    if (features_one_reg[dcr_pkg::OSC_MSB:0] == dcr_pkg::OSC_UNDEFINED)
      reg_cfg.oscillator_freq_select = dcr_pkg::OSC_OFF;
    else
      reg_cfg.oscillator_freq_select = features_one_reg[dcr_pkg::OSC_MSB:0];
  end

  assign hold_low_feature = hold_low_strap &
                            ~features_one_reg[dcr_pkg::STRAP_BYPASS_BIT];
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      eff_cfg_reg   <= '0;
      sleep_reg     <= 1'b0;
      drive_en_reg  <= 1'b1;
      force_low_reg <= 1'b0;
      pass_high_reg <= 1'b0;
    end
    else
    begin
      eff_cfg_reg  <= config_one_reg[dcr_pkg::REG_CONTROL_BIT] ? reg_cfg : pin_cfg;
      sleep_reg    <= config_one_reg[dcr_pkg::SLEEP_BIT];
      drive_en_reg <= ~config_one_reg[dcr_pkg::SLEEP_BIT] |
                      features_one_reg[dcr_pkg::SLEEP_STATE_BIT];
      force_low_reg <= (config_one_reg[dcr_pkg::SLEEP_BIT] &
                        features_one_reg[dcr_pkg::SLEEP_STATE_BIT]) |
                       (hold_low_feature & lock_status &
                        ~features_one_reg[dcr_pkg::HOLD_LOW_BIT]);
      pass_high_reg <= config_one_reg[dcr_pkg::SLEEP_BIT];
    end
  end

  assign sda_out          = 1'b0;
  assign sda_oe           = sda_oe_reg;
  assign eff_cfg          = eff_cfg_reg;
  assign sleep_mode       = sleep_reg;
  assign out_drive_enable = drive_en_reg;
  assign out_force_low    = force_low_reg;
  assign pass_force_high  = pass_high_reg;
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  spread_range_a: assert property (
    config_one_reg[dcr_pkg::REG_CONTROL_BIT] |=>
      eff_cfg_reg.low_freq_spread_range == $past(config_one_reg[dcr_pkg::LF_RANGE_BIT]))
    else $error("spread range not from register");
  clock_slew_a: assert property (
    config_one_reg[dcr_pkg::REG_CONTROL_BIT] |=>
      eff_cfg_reg.clock_output_slew_boost == $past(config_one_reg[dcr_pkg::CLK_SLEW_BIT]))
    else $error("clock slew not from register");
  data_slew_a: assert property (
    config_one_reg[dcr_pkg::REG_CONTROL_BIT] |=>
      eff_cfg_reg.data_output_slew_boost == $past(config_one_reg[dcr_pkg::DATA_SLEW_BIT]))
    else $error("data slew not from register");
  strobe_edge_a: assert property (
    config_one_reg[dcr_pkg::REG_CONTROL_BIT] |=>
      eff_cfg_reg.output_strobe_edge_select ==
      $past(config_one_reg[dcr_pkg::STROBE_EDGE_BIT]))
    else $error("strobe edge not from register");
  filter_mode_a: assert property (
    (config_one_reg[dcr_pkg::REG_CONTROL_BIT] && config_one_reg[dcr_pkg::MODE_MSB]) |=>
      !eff_cfg_reg.filter_enable)
    else $error("reserved mode enabled filter");
  pin_source_a: assert property (
    !config_one_reg[dcr_pkg::REG_CONTROL_BIT] |=> eff_cfg_reg == $past(pin_cfg))
    else $error("pin settings not followed");
  sleep_float_a: assert property (
    (config_one_reg[dcr_pkg::SLEEP_BIT] && !features_one_reg[dcr_pkg::SLEEP_STATE_BIT])
      |=> !out_drive_enable && pass_force_high && sleep_mode)
    else $error("sleep outputs still driven");
  hold_low_a: assert property (
    (lock_status && hold_low_strap && !features_one_reg[dcr_pkg::STRAP_BYPASS_BIT] &&
     !features_one_reg[dcr_pkg::HOLD_LOW_BIT]) |=> out_force_low)
    else $error("outputs not held low");
  osc_reserved_a: assert property (
    (config_one_reg[dcr_pkg::REG_CONTROL_BIT] &&
     features_one_reg[dcr_pkg::OSC_MSB:0] == dcr_pkg::OSC_UNDEFINED) |=>
      eff_cfg_reg.oscillator_freq_select == dcr_pkg::OSC_OFF)
    else $error("undefined oscillator code used");
  write_lands_a: assert property (
    (wr_stb_reg && wr_addr_reg == dcr_pkg::OFS_SLAVE_ADDR) |=>
      slave_addr_reg == $past(wr_data_reg))
    else $error("address write lost");

  addr_ack_c:  cover property (state_reg == dcr_pkg::ST_ADDR_ACK);
  reg_write_c: cover property (wr_stb_reg ##1 config_one_reg[dcr_pkg::REG_CONTROL_BIT]);
  read_ack_c:  cover property (state_reg == dcr_pkg::ST_RDATA_ACK && master_ack_reg);
endmodule : dcr_config_regs

`default_nettype wire

// ==== sim/dcr_host_model.sv ====
// Host model for the two-wire serial control bus of the register bank
`timescale 1ns/1ns
`default_nettype none

module dcr_host_model (
  // Clock
  input  wire logic core_clk,
  // Bus lines, SDA is open drain with a pull-up
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Four cycles a phase keeps each SCL level above the three-cycle floor
  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask : half

  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    half();
    scl <= 1'b1;
    half();
    r = sda_line;
    scl <= 1'b0;
    half();
  endtask : bit_io

  task automatic start_cond();
    sda_low <= 1'b0;
    scl     <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask : start_cond

  task automatic stop_cond();
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask : stop_cond

  // Ack is high when the device pulled SDA low on the ninth bit
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : recv_byte

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] ptr,
                           input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start_cond();
    send_byte({addr, 1'b0}, a0);
    send_byte(ptr, a1);
    send_byte(data, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : write_reg

  // Pointer write, then repeated start and a single read byte
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] ptr,
                          output logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start_cond();
    send_byte({addr, 1'b0}, a0);
    send_byte(ptr, a1);
    start_cond();
    send_byte({addr, 1'b1}, a2);
    recv_byte(1'b1, data);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : read_reg

  // Two data bytes in one frame, pointer advancing between them
  task automatic write_pair(input logic [6:0] addr, input logic [7:0] ptr,
                            input logic [7:0] d0, input logic [7:0] d1, output logic ok);
    logic a0, a1, a2, a3;
    start_cond();
    send_byte({addr, 1'b0}, a0);
    send_byte(ptr, a1);
    send_byte(d0, a2);
    send_byte(d1, a3);
    stop_cond();
    ok = a0 & a1 & a2 & a3;
  endtask : write_pair

  // Host acks the first byte read, so the device must send a second
  task automatic read_pair(input logic [6:0] addr, input logic [7:0] ptr,
                           output logic [7:0] d0, output logic [7:0] d1, output logic ok);
    logic a0, a1, a2;
    start_cond();
    send_byte({addr, 1'b0}, a0);
    send_byte(ptr, a1);
    start_cond();
    send_byte({addr, 1'b1}, a2);
    recv_byte(1'b0, d0);
    recv_byte(1'b1, d1);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : read_pair
endmodule : dcr_host_model

`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic              core_clk, reset, host_scl, host_low, sda_line, sda_out, sda_oe;
  logic [1:0]        address_select_pin;
  dcr_pkg::dcr_cfg_s pin_cfg, eff_cfg;
  logic              hold_low_strap, lock_status, sleep_mode;
  logic              out_drive_enable, out_force_low, pass_force_high;
  int                error_cnt, samples_checked, cycle_cnt;
  logic [6:0]        dev_addr;
  logic              ok;
  logic [7:0]        rd;

  ////////////////////////////////////////////////////////////////////////////
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~host_low;

  dcr_config_regs i_dcr_config_regs (.core_clk(core_clk), .reset(reset),
    .scl_in(host_scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin(address_select_pin), .pin_cfg(pin_cfg),
    .hold_low_strap(hold_low_strap), .lock_status(lock_status), .eff_cfg(eff_cfg),
    .sleep_mode(sleep_mode), .out_drive_enable(out_drive_enable),
    .out_force_low(out_force_low), .pass_force_high(pass_force_high));

  dcr_host_model i_dcr_host_model (.core_clk(core_clk), .scl(host_scl),
    .sda_low(host_low), .sda_line(sda_line));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // About 25k cycles of traffic expected
  always @(posedge core_clk)
  begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 60000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask : settle

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    i_dcr_host_model.write_reg(dev_addr, ptr, data, ok);
    check_byte({7'h00, ok}, 8'h01);
  endtask : wr

  task automatic rdchk(input logic [7:0] ptr, input logic [7:0] exp);
    i_dcr_host_model.read_reg(dev_addr, ptr, rd, ok);
    check_byte({7'h00, ok}, 8'h01);
    check_byte(rd, exp);
  endtask : rdchk

  // Sleep, drive enable, force low, pass high
  task automatic check_outs(input logic [3:0] exp);
    settle();
    check_byte({4'h0, sleep_mode, out_drive_enable, out_force_low, pass_force_high},
               {4'h0, exp});
  endtask : check_outs

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_and_pins();
    rdchk(dcr_pkg::OFS_CONFIG_ONE, 8'h00);
    rdchk(dcr_pkg::OFS_SLAVE_ADDR, 8'h70);
    rdchk(dcr_pkg::OFS_FEATURES_ONE, 8'h00);
    pin_cfg <= 8'h59;
    settle();
    check_byte(eff_cfg, 8'h59);
    pin_cfg <= 8'ha6;
    settle();
    check_byte(eff_cfg, 8'ha6);
  endtask : test_reset_and_pins

  task automatic test_config();
    logic [7:0] vals [8] = '{8'h81, 8'h41, 8'h21, 8'h11, 8'h05, 8'h09, 8'h0d, 8'h01};
    wr(8'h02, 8'h80);
    foreach (vals[i])
    begin
      wr(8'h00, vals[i]);
      settle();
      check_byte(eff_cfg, {vals[i][7:4], vals[i][3:2] == 2'h1, 3'h0});
      rdchk(8'h00, vals[i]);
    end
    wr(8'h00, 8'h00);
    settle();
    check_byte(eff_cfg, 8'ha6);
  endtask : test_config

  task automatic test_osc();
    wr(8'h00, 8'h01);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h02, 8'h80 | 8'(c));
      settle();
      check_byte(eff_cfg, (c == 5) ? 8'h00 : 8'(c));
      rdchk(8'h02, 8'h80 | 8'(c));
    end
  endtask : test_osc

  task automatic test_sleep();
    wr(8'h02, 8'h80);
    wr(8'h00, 8'h03);
    check_outs(4'h9);
    rdchk(8'h02, 8'h80);
    wr(8'h02, 8'hc0);
    check_outs(4'hf);
    wr(8'h00, 8'h01);
    check_outs(4'h4);
  endtask : test_sleep

  task automatic test_hold();
    lock_status    <= 1'b1;
    hold_low_strap <= 1'b1;
    wr(8'h02, 8'h00);
    check_outs(4'h6);
    wr(8'h02, 8'h08);
    check_outs(4'h4);
    wr(8'h02, 8'h00);
    lock_status <= 1'b0;
    check_outs(4'h4);
    lock_status    <= 1'b1;
    hold_low_strap <= 1'b0;
    check_outs(4'h4);
    hold_low_strap <= 1'b1;
    wr(8'h02, 8'h80);
    check_outs(4'h4);
  endtask : test_hold

  task automatic test_addr();
    logic [6:0] pin_addr [4] = '{7'h71, 7'h72, 7'h73, 7'h76};
    wr(8'h01, 8'hf6);
    i_dcr_host_model.read_reg(7'h71, 8'h01, rd, ok);
    check_byte({7'h00, ok}, 8'h00);
    dev_addr = 7'h76;
    rdchk(8'h01, 8'hf6);
    wr(8'h01, 8'h72);
    foreach (pin_addr[p])
    begin
      address_select_pin <= 2'(p);
      dev_addr = pin_addr[p];
      settle();
      rdchk(8'h01, 8'h72);
    end
    address_select_pin <= 2'h0;
    dev_addr = 7'h71;
    settle();
  endtask : test_addr

  // Burst frames: pointer must advance after each data byte both ways
  task automatic test_burst();
    logic [7:0] d0, d1;
    i_dcr_host_model.write_pair(dev_addr, 8'h01, 8'h72, 8'h85, ok);
    check_byte({7'h00, ok}, 8'h01);
    i_dcr_host_model.read_pair(dev_addr, 8'h00, d0, d1, ok);
    check_byte({7'h00, ok}, 8'h01);
    check_byte(d0, 8'h01);
    check_byte(d1, 8'h72);
    rdchk(8'h02, 8'h85);
  endtask : test_burst

  task automatic test_unmapped();
    wr(8'h03, 8'h5a);
    rdchk(8'h03, 8'h00);
    rdchk(8'h00, 8'h01);
  endtask : test_unmapped

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset              = 1'b1;
    address_select_pin = 2'h0;
    pin_cfg            = 8'h00;
    hold_low_strap     = 1'b0;
    lock_status        = 1'b0;
    error_cnt          = 0;
    samples_checked    = 0;
    cycle_cnt          = 0;
    dev_addr           = 7'h71;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    test_reset_and_pins();
    test_config();
    test_osc();
    test_sleep();
    test_hold();
    test_addr();
    test_burst();
    test_unmapped();
    complete_run();
  end
endmodule : testbench

`default_nettype wire
